// ### rfsup_pkg.sv
/*
 * Shared constants and types of the radio supervisor and fault reporter.
 * Assumes a single 10 MHz clock; command codes are local encodings that an
 * upstream command parser produces from the host's text commands.
 */
package rfsup_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 10;
    localparam int ACK_TIMEOUT_US = 10;
    localparam int INIT_TIMEOUT_US = 100;
    localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * CLK_MHZ;
    localparam int INIT_TIMEOUT_CYC = INIT_TIMEOUT_US * CLK_MHZ;
    // ****************************************
    // Command codes and status values
    // ****************************************
    localparam logic [7:0] CMD_RF_OFF = 8'h40;
    localparam logic [7:0] CMD_RF_ON = 8'h41;
    localparam logic [7:0] CMD_FREQ_SET = 8'h47;
    localparam logic [7:0] CMD_RF_STATUS = 8'h27;
    localparam logic [7:0] CMD_EXT_TAG_ON = 8'h89;
    localparam logic [7:0] CMD_EXT_TAG_OFF = 8'h88;
    localparam logic [7:0] CMD_DIAG = 8'h50;
    localparam logic [7:0] CMD_PARAM_UPDATE = 8'h44;
    localparam logic [7:0] RF_STATUS_EXPECTED = 8'h00;
    localparam logic [7:0] DATA_NONE = 8'h00;
    localparam int NUM_KINDS = 10;
    // ****************************************
    // Types
    // ****************************************
    // Lower code wins when several messages wait.
    typedef enum logic [3:0] {
        K_PLL_UNLOCK = 4'h0,
        K_PARAM_LOST = 4'h1,
        K_PLL_RELOCK = 4'h2,
        K_ERROR = 4'h3,
        K_DONE = 4'h4,
        K_RF_STATUS = 4'h5,
        K_WIEGAND = 4'h6,
        K_ACK_MISSING = 4'h7,
        K_INIT_TIMEOUT = 4'h8,
        K_BAD_STATUS = 4'h9
    } rfsup_kind_type;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_UNLOCK = 2'b01,
        ST_NV_HOLD = 2'b10
    } rfsup_state_type;
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic args_ok;
        logic diag_pass;
    } rfsup_cmd_type;
    typedef struct packed {
        rfsup_kind_type kind;
        logic [7:0] data;
    } rfsup_msg_type;
endpackage

// ### rfsup_sync.sv
/*
 * Two-flop synchroniser for a bundle of level inputs.
 * Assumes each bit is a slow level from a pin, not a bus needing coherence.
 */
`timescale 1ns/100ps
module rfsup_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= '0;
            q_ff <= '0;
        end
        else
        begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
    assign q = q_ff;
endmodule

// ### rfsup_watchdog.sv
/*
 * Handshake watchdog: armed by start, disarmed by done, and pulses expired
 * when done has not come within CYCLES clocks. Assumes same-clock inputs.
 */
`timescale 1ns/100ps
module rfsup_watchdog #(
    parameter int CYCLES = 100
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Handshake
    input wire logic start,
    input wire logic done,
    output logic expired
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_ff;
    logic armed_ff;
    logic expired_ff;
    wire at_end = armed_ff && (cnt_ff == W'(CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= '0;
            armed_ff <= 1'b0;
            expired_ff <= 1'b0;
        end
        else
        begin
            expired_ff <= at_end && !done && !start;
            cnt_ff <= (start || !armed_ff) ? '0 : cnt_ff + 1'b1;
            armed_ff <= start || (armed_ff && !done && !at_end);
        end
    end
    assign expired = expired_ff;
endmodule

// ### rfsup_top.sv
/*
 * Radio supervisor and fault reporter: checks host commands, gates RF on
 * parameter loss and on a PLL unlock seen in ST_RUN, watches RF module handshakes, and queues
 * one message at a time towards the host link.
 * Assumes an upstream parser feeding decoded commands and a downstream
 * serialiser taking messages, both on clk; RF module flags arrive on pins.
 */
`timescale 1ns/100ps
// Notes on behaviour
// R1 - Unknown command or bad arguments answers with an error message.
// R2 - Failed diagnostic self-test answers with an error, not a pass.
// R3 - Lost parameters report an error and hold RF off until frequency set.
// R4 - PLL unlock reports an error, disables RF and resets the PLL; only a lock_fall in ST_RUN does so, without a coinciding nv_rise.
// R5 - On relock report notice once after unlock; restore previous RF state.
// R6 - Wiegand tag in ID-only mode reports conflict; extended mode allows it.
// R7 - Missing acknowledge after parameter update raises a warning.
// R8 - Missing init-done from the RF module raises a warning.
// R9 - Unexpected RF status raises a warning carrying the status byte.
// R10 - RF status query answers whether RF output is on or off.
// R11 - Warnings never latch a fault; each occurrence after its flag clears is reported. Repeats while the flag is pending merge into one message.
module rfsup_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Decoded host commands
    input wire rfsup_pkg::rfsup_cmd_type cmd,
    output logic cmd_ready,
    // Messages to the host
    output logic msg_valid,
    output rfsup_pkg::rfsup_msg_type msg,
    input wire logic msg_ready,
    // RF module pins
    input wire logic nv_lost_pin,
    input wire logic pll_lock_pin,
    input wire logic rf_ack_pin,
    input wire logic rf_init_done_pin,
    // RF status reads
    input wire logic rf_stat_valid,
    input wire logic [7:0] rf_stat_byte,
    // Tag reads
    input wire logic tag_valid,
    input wire logic tag_wiegand,
    input wire logic wiegand_out_sel,
    // RF control
    output logic rf_enable,
    output logic pll_reset,
    output logic extended_tag_mode
);
    import rfsup_pkg::*;

    // ****************************************
    // Synchronised pins and edges
    // ****************************************
    logic [3:0] pins_s;
    logic nv_s_d_ff;
    logic lock_s_d_ff;
    logic ack_s_d_ff;
    rfsup_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({nv_lost_pin, pll_lock_pin, rf_ack_pin, rf_init_done_pin}),
        .q(pins_s)
    );
    wire nv_s = pins_s[3];
    wire lock_s = pins_s[2];
    wire ack_s = pins_s[1];
    wire init_s = pins_s[0];
    wire nv_rise = nv_s && !nv_s_d_ff;
    wire lock_fall = lock_s_d_ff && !lock_s;
    wire ack_rise = ack_s && !ack_s_d_ff;

    // ****************************************
    // Command decode
    // ****************************************
    function automatic logic is_known(input logic [7:0] c);
        is_known = (c == CMD_RF_OFF) || (c == CMD_RF_ON) ||
            (c == CMD_FREQ_SET) || (c == CMD_RF_STATUS) ||
            (c == CMD_EXT_TAG_ON) || (c == CMD_EXT_TAG_OFF) ||
            (c == CMD_DIAG) || (c == CMD_PARAM_UPDATE);
    endfunction

    function automatic logic [3:0] pick_first(input logic [NUM_KINDS-1:0] p);
        pick_first = 4'h0;
        for (int i = NUM_KINDS - 1; i >= 0; i--)
        begin
            if (p[i])
            begin
                pick_first = 4'(i);
            end
        end
    endfunction

    logic cmd_ready_ff;
    wire cmd_take = cmd.valid && cmd_ready_ff;
    wire cmd_ok = cmd_take && is_known(cmd.code) && cmd.args_ok;
    wire cmd_bad = cmd_take && !(is_known(cmd.code) && cmd.args_ok);
    wire diag_fail = cmd_ok && (cmd.code == CMD_DIAG) && !cmd.diag_pass;
    wire stat_query = cmd_ok && (cmd.code == CMD_RF_STATUS);
    wire freq_set = cmd_ok && (cmd.code == CMD_FREQ_SET);
    wire upd_cmd = cmd_ok && (cmd.code == CMD_PARAM_UPDATE);
    wire cmd_err = cmd_bad || diag_fail; // R1 R2
    wire cmd_done = cmd_ok && !diag_fail && !stat_query;

    // ****************************************
    // RF gating state
    // ****************************************
    rfsup_state_type state_ff;
    rfsup_state_type nxt_state;
    logic rf_want_ff;
    logic nxt_rf_want;
    logic saved_ff;
    logic ext_mode_ff;
    logic rf_enable_ff;
    logic pll_reset_ff;

    wire go_unlock = (state_ff == ST_RUN) && lock_fall && !nv_rise;
    // A parameter loss that coincides with relock wins, so no notice is
    // queued while RF stays held off.
    wire relock = (state_ff == ST_UNLOCK) && lock_s && !nv_rise;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN:
            begin
                if (nv_rise)
                begin
                    nxt_state = ST_NV_HOLD; // R3
                end
                else if (lock_fall)
                begin
                    nxt_state = ST_UNLOCK; // R4
                end
            end
            ST_UNLOCK:
            begin
                if (nv_rise)
                begin
                    nxt_state = ST_NV_HOLD;
                end
                else if (lock_s)
                begin
                    nxt_state = ST_RUN; // R5
                end
            end
            ST_NV_HOLD:
            begin
                if (freq_set)
                begin
                    nxt_state = ST_RUN; // R3
                end
            end
            default:
            begin
                nxt_state = ST_NV_HOLD;
            end
        endcase
    end

    always_comb
    begin
        nxt_rf_want = rf_want_ff;
        if (relock)
        begin
            nxt_rf_want = saved_ff; // R5
        end
        else if (cmd_ok && (cmd.code == CMD_RF_ON))
        begin
            nxt_rf_want = 1'b1;
        end
        else if (cmd_ok && (cmd.code == CMD_RF_OFF))
        begin
            nxt_rf_want = 1'b0;
        end
    end

    // RF is gated by state, so a host RF-on during a fault cannot leak out.
    wire nxt_rf_enable = nxt_rf_want && (nxt_state == ST_RUN); // R3 R4

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_RUN;
            rf_want_ff <= 1'b1;
            saved_ff <= 1'b1;
            ext_mode_ff <= 1'b0;
            rf_enable_ff <= 1'b0;
            pll_reset_ff <= 1'b0;
            nv_s_d_ff <= 1'b0;
            lock_s_d_ff <= 1'b0;
            ack_s_d_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            rf_want_ff <= nxt_rf_want;
            saved_ff <= go_unlock ? rf_want_ff : saved_ff;
            if (cmd_ok && (cmd.code == CMD_EXT_TAG_ON))
            begin
                ext_mode_ff <= 1'b1; // R6
            end
            else if (cmd_ok && (cmd.code == CMD_EXT_TAG_OFF))
            begin
                ext_mode_ff <= 1'b0;
            end
            rf_enable_ff <= nxt_rf_enable;
            pll_reset_ff <= (nxt_state == ST_UNLOCK); // R4
            nv_s_d_ff <= nv_s;
            lock_s_d_ff <= lock_s;
            ack_s_d_ff <= ack_s;
        end
    end

    // ****************************************
    // RF module handshake watchdogs
    // ****************************************
    logic ack_expire;
    logic init_expire;
    logic init_start_ff;
    rfsup_watchdog #(.CYCLES(ACK_TIMEOUT_CYC)) u_ack_wd (
        .clk(clk),
        .rst_n(rst_n),
        .start(upd_cmd),
        .done(ack_rise),
        .expired(ack_expire)
    );
    // Armed after reset and again on each frequency set, which re-inits.
    rfsup_watchdog #(.CYCLES(INIT_TIMEOUT_CYC)) u_init_wd (
        .clk(clk),
        .rst_n(rst_n),
        .start(init_start_ff),
        .done(init_s),
        .expired(init_expire)
    );

    // ****************************************
    // Pending messages and output
    // ****************************************
    logic [NUM_KINDS-1:0] pend_ff;
    logic [NUM_KINDS-1:0] set_vec;
    logic [NUM_KINDS-1:0] clr_vec;
    logic [7:0] bad_byte_ff;
    logic rfst_ff;
    logic msg_valid_ff;
    rfsup_msg_type msg_ff;
    wire stat_bad = rf_stat_valid && (rf_stat_byte != RF_STATUS_EXPECTED);
    wire wieg_bad = tag_valid && tag_wiegand && wiegand_out_sel &&
        !ext_mode_ff;
    wire msg_load = !msg_valid_ff && (|pend_ff);
    wire [3:0] pick = pick_first(pend_ff);
    wire [7:0] pick_data = (pick == K_BAD_STATUS) ? bad_byte_ff :
        (pick == K_RF_STATUS) ? {7'h00, rfst_ff} : DATA_NONE;
    wire cmd_pend_next = |(((pend_ff & ~clr_vec) | set_vec) &
        ((NUM_KINDS)'(1) << K_ERROR | (NUM_KINDS)'(1) << K_DONE |
        (NUM_KINDS)'(1) << K_RF_STATUS));

    always_comb
    begin
        set_vec = '0;
        set_vec[K_ERROR] = cmd_err; // R1 R2
        set_vec[K_DONE] = cmd_done;
        set_vec[K_RF_STATUS] = stat_query; // R10
        set_vec[K_PARAM_LOST] = nv_rise; // R3
        set_vec[K_PLL_UNLOCK] = go_unlock; // R4
        set_vec[K_PLL_RELOCK] = relock; // R5
        set_vec[K_WIEGAND] = wieg_bad; // R6
        set_vec[K_ACK_MISSING] = ack_expire; // R7
        set_vec[K_INIT_TIMEOUT] = init_expire; // R8
        set_vec[K_BAD_STATUS] = stat_bad; // R9
        clr_vec = '0;
        clr_vec[pick] = msg_load;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_ff <= '0;
            bad_byte_ff <= DATA_NONE;
            rfst_ff <= 1'b0;
            msg_valid_ff <= 1'b0;
            msg_ff <= '{kind: K_DONE, data: DATA_NONE};
            cmd_ready_ff <= 1'b0;
            init_start_ff <= 1'b1;
        end
        else
        begin
            // Sending clears the flag, so no fault latches. R11
            pend_ff <= (pend_ff & ~clr_vec) | set_vec;
            bad_byte_ff <= stat_bad ? rf_stat_byte : bad_byte_ff; // R9
            rfst_ff <= stat_query ? rf_enable_ff : rfst_ff; // R10
            if (msg_load)
            begin
                msg_valid_ff <= 1'b1;
                msg_ff <= '{kind: rfsup_kind_type'(pick), data: pick_data};
            end
            else if (msg_ready)
            begin
                msg_valid_ff <= 1'b0;
            end
            // One command in flight until its answer has been queued out.
            cmd_ready_ff <= !cmd_pend_next;
            init_start_ff <= freq_set;
        end
    end

    assign cmd_ready = cmd_ready_ff;
    assign msg_valid = msg_valid_ff;
    assign msg = msg_ff;
    assign rf_enable = rf_enable_ff;
    assign pll_reset = pll_reset_ff;
    assign extended_tag_mode = ext_mode_ff;

    // ****************************************
    // Assertions
    // ****************************************
    bad_cmd_error_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
        cmd_take && !is_known(cmd.code) |=> pend_ff[K_ERROR] && !cmd_ready)
        else $error("Unknown command did not queue an error.");
    diag_fail_error_a: assert property (@(posedge clk) // R2
        disable iff (!rst_n)
        cmd_take && cmd.code == CMD_DIAG && cmd.args_ok && !cmd.diag_pass
        |=> pend_ff[K_ERROR] && !pend_ff[K_DONE])
        else $error("Failed diagnostic was not answered with an error.");
    nv_hold_off_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
        state_ff == ST_RUN && nv_rise |=> pend_ff[K_PARAM_LOST]
        ##1 (!rf_enable && state_ff == ST_NV_HOLD) [*2])
        else $error("Parameter loss did not hold RF off.");
    unlock_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
        go_unlock |=> pend_ff[K_PLL_UNLOCK] && !rf_enable && pll_reset)
        else $error("PLL unlock did not gate RF and reset the PLL.");
    relock_restore_a: assert property (@(posedge clk) // R5
        disable iff (!rst_n)
        relock |=> pend_ff[K_PLL_RELOCK] && !pll_reset &&
        rf_enable == $past(saved_ff))
        else $error("Relock did not restore the RF state.");
    relock_after_unlock_a: assert property (@(posedge clk) // R5
        disable iff (!rst_n)
        $rose(pend_ff[K_PLL_RELOCK]) |-> $past(state_ff) == ST_UNLOCK)
        else $error("Relock notice without a prior unlock.");
    wiegand_conflict_a: assert property (@(posedge clk) // R6
        disable iff (!rst_n)
        tag_valid && tag_wiegand && wiegand_out_sel && !extended_tag_mode
        |=> pend_ff[K_WIEGAND])
        else $error("Wiegand conflict not reported.");
    ack_warning_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
        ack_expire |-> $past(upd_cmd, ACK_TIMEOUT_CYC + 1)
        ##1 pend_ff[K_ACK_MISSING])
        else $error("Missing acknowledge not reported.");
    init_warning_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
        init_expire |=> pend_ff[K_INIT_TIMEOUT])
        else $error("Init timeout not reported.");
    bad_status_byte_a: assert property (@(posedge clk) // R9
        disable iff (!rst_n)
        stat_bad |=> pend_ff[K_BAD_STATUS] &&
        bad_byte_ff == $past(rf_stat_byte))
        else $error("Bad status warning lost its byte.");
    status_reply_a: assert property (@(posedge clk) // R10
        disable iff (!rst_n)
        stat_query |=> pend_ff[K_RF_STATUS] && rfst_ff == $past(rf_enable))
        else $error("RF status reply does not match RF output.");
    warn_release_a: assert property (@(posedge clk) // R11
        disable iff (!rst_n)
        msg_load && pick == K_ACK_MISSING && !ack_expire
        |=> !pend_ff[K_ACK_MISSING] && msg.kind == K_ACK_MISSING)
        else $error("Sent warning stayed latched.");
endmodule

// ### rfsup_host_model.sv
/*
 * Host-side model: presents one decoded command at a time and accepts
 * messages, logging which kinds arrived and the data of the last one.
 * Assumes the bench pulses go for one clock with the command fields set.
 */
`timescale 1ns/100ps
module rfsup_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench control
    input wire logic go,
    input wire logic [7:0] go_code,
    input wire logic go_args_ok,
    input wire logic go_diag_pass,
    input wire logic stall,
    input wire logic clr,
    output logic busy,
    output logic [rfsup_pkg::NUM_KINDS-1:0] seen,
    output logic [7:0] last_data,
    // Device side
    output rfsup_pkg::rfsup_cmd_type cmd,
    input wire logic cmd_ready,
    input wire logic msg_valid,
    input wire rfsup_pkg::rfsup_msg_type msg,
    output logic msg_ready
);
    import rfsup_pkg::*;
    assign busy = cmd.valid;
    // A stalled host simply withholds ready; the device must keep waiting.
    assign msg_ready = !stall;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd <= '{1'b0, 8'hFF, 1'b0, 1'b0};
            seen <= '0;
            last_data <= 8'h00;
        end
        else
        begin
            // Once taken, the code is scrambled so stale values never match.
            if (cmd.valid && cmd_ready)
            begin
                cmd.valid <= 1'b0;
                cmd.code <= ~cmd.code;
            end
            else if (go && !cmd.valid)
            begin
                cmd <= '{1'b1, go_code, go_args_ok, go_diag_pass};
            end
            if (clr)
            begin
                seen <= '0;
            end
            if (msg_valid && msg_ready)
            begin
                seen[msg.kind] <= 1'b1;
                last_data <= msg.data;
            end
        end
    end
endmodule

// ### testbench.sv
/*
 * Self-checking bench of the radio supervisor: a table of host commands,
 * then PLL, parameter loss, Wiegand, status and handshake cases.
 * Assumes the host model on the command and message side.
 */
`timescale 1ns/100ps
module testbench;
    import rfsup_pkg::*;
    typedef struct packed {
        logic [7:0] code;
        logic args;
        logic diag;
        rfsup_kind_type kind;
        logic rf;
    } rfsup_row_type;
    // ****************************************
    // Stimulus and wiring
    // ****************************************
    localparam rfsup_row_type ROWS [12] = '{
        '{CMD_RF_STATUS, 1'b1, 1'b1, K_RF_STATUS, 1'b1},
        '{CMD_RF_OFF, 1'b1, 1'b1, K_DONE, 1'b0},
        '{CMD_RF_STATUS, 1'b1, 1'b1, K_RF_STATUS, 1'b0},
        '{8'hFF, 1'b1, 1'b1, K_ERROR, 1'b0},
        '{CMD_RF_ON, 1'b0, 1'b1, K_ERROR, 1'b0},
        '{CMD_RF_ON, 1'b1, 1'b1, K_DONE, 1'b1},
        '{CMD_DIAG, 1'b1, 1'b1, K_DONE, 1'b1},
        '{CMD_DIAG, 1'b1, 1'b0, K_ERROR, 1'b1},
        '{CMD_EXT_TAG_ON, 1'b1, 1'b1, K_DONE, 1'b1},
        '{CMD_EXT_TAG_OFF, 1'b1, 1'b1, K_DONE, 1'b1},
        '{CMD_FREQ_SET, 1'b1, 1'b1, K_DONE, 1'b1},
        '{CMD_RF_STATUS, 1'b1, 1'b1, K_RF_STATUS, 1'b1}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic [7:0] go_code = 8'h00;
    logic go_args_ok = 1'b1;
    logic go_diag_pass = 1'b1;
    logic stall = 1'b0;
    logic clr = 1'b0;
    logic nv_lost_pin = 1'b0;
    logic pll_lock_pin = 1'b1;
    logic rf_ack_pin = 1'b0;
    logic rf_init_done_pin = 1'b1;
    logic rf_stat_valid = 1'b0;
    logic [7:0] rf_stat_byte = 8'h00;
    logic tag_valid = 1'b0;
    logic tag_wiegand = 1'b0;
    logic wiegand_out_sel = 1'b0;
    logic busy;
    logic [NUM_KINDS-1:0] seen;
    logic [7:0] last_data;
    rfsup_cmd_type cmd;
    rfsup_msg_type msg;
    logic cmd_ready;
    logic msg_valid;
    logic msg_ready;
    logic rf_enable;
    logic pll_reset;
    logic extended_tag_mode;
    int n_fail = 0;
    int n_checks = 0;
    rfsup_top dut_u (.clk(clk), .rst_n(rst_n), .cmd(cmd),
        .cmd_ready(cmd_ready), .msg_valid(msg_valid), .msg(msg),
        .msg_ready(msg_ready), .nv_lost_pin(nv_lost_pin),
        .pll_lock_pin(pll_lock_pin), .rf_ack_pin(rf_ack_pin),
        .rf_init_done_pin(rf_init_done_pin), .rf_stat_valid(rf_stat_valid),
        .rf_stat_byte(rf_stat_byte), .tag_valid(tag_valid),
        .tag_wiegand(tag_wiegand), .wiegand_out_sel(wiegand_out_sel),
        .rf_enable(rf_enable), .pll_reset(pll_reset),
        .extended_tag_mode(extended_tag_mode));
    rfsup_host_model host_u (.clk(clk), .rst_n(rst_n), .go(go),
        .go_code(go_code), .go_args_ok(go_args_ok),
        .go_diag_pass(go_diag_pass), .stall(stall), .clr(clr), .busy(busy),
        .seen(seen), .last_data(last_data), .cmd(cmd),
        .cmd_ready(cmd_ready), .msg_valid(msg_valid), .msg(msg),
        .msg_ready(msg_ready));
    initial
    begin
        forever #50 clk = ~clk;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [7:0] got,
                         input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic clear;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic wait_kind(input rfsup_kind_type k, input int lim);
        int i;
        for (i = 0; i < lim && seen[k] !== 1'b1; i++)
            tick(1);
    endtask
    // Clears the log, then waits until the command has been taken.
    task automatic send(input logic [7:0] c, input logic a, input logic d);
        int i;
        clear();
        @(posedge clk);
        go_code <= c;
        go_args_ok <= a;
        go_diag_pass <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (i = 0; i < 50 && busy !== 1'b0; i++)
            tick(1);
    endtask
    task automatic pin_event(input int which, input logic [7:0] b);
        @(posedge clk);
        rf_stat_byte <= b;
        rf_stat_valid <= (which == 0);
        tag_valid <= (which == 1);
        tag_wiegand <= 1'b1;
        wiegand_out_sel <= 1'b1;
        @(posedge clk);
        rf_stat_valid <= 1'b0;
        tag_valid <= 1'b0;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        #(100 * 8000);
        n_fail++;
        wrap_up();
    end
    initial
    begin
        tick(4);
        check("reset outputs", {cmd_ready, msg_valid, rf_enable, pll_reset,
              extended_tag_mode}, 8'h00);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tick(12);
        check("rf after reset", rf_enable, 1'b1);
        check("quiet after reset", seen[K_PLL_RELOCK], 1'b0);
        foreach (ROWS[r])
        begin
            send(ROWS[r].code, ROWS[r].args, ROWS[r].diag);
            wait_kind(ROWS[r].kind, 20);
            check("answer kind", seen[ROWS[r].kind], 1'b1);
            check("rf state", rf_enable, ROWS[r].rf);
            check("ready again", cmd_ready, 1'b1);
            if (ROWS[r].kind == K_RF_STATUS)
                check("status data", last_data[0], ROWS[r].rf);
        end
        // Relock restores whichever state RF had before the loss.
        for (int p = 0; p < 2; p++)
        begin
            send(p ? CMD_RF_ON : CMD_RF_OFF, 1'b1, 1'b1);
            wait_kind(K_DONE, 20);
            @(posedge clk);
            pll_lock_pin <= 1'b0;
            wait_kind(K_PLL_UNLOCK, 20);
            check("unlock kind", seen[K_PLL_UNLOCK], 1'b1);
            check("rf in unlock", rf_enable, 1'b0);
            check("pll reset", pll_reset, 1'b1);
            check("early relock", seen[K_PLL_RELOCK], 1'b0);
            @(posedge clk);
            pll_lock_pin <= 1'b1;
            wait_kind(K_PLL_RELOCK, 20);
            tick(2);
            check("relock kind", seen[K_PLL_RELOCK], 1'b1);
            check("rf restored", rf_enable, p[0]);
            check("pll reset off", pll_reset, 1'b0);
        end
        clear();
        @(posedge clk);
        nv_lost_pin <= 1'b1;
        wait_kind(K_PARAM_LOST, 20);
        check("param lost", seen[K_PARAM_LOST], 1'b1);
        nv_lost_pin <= 1'b0;
        send(CMD_RF_ON, 1'b1, 1'b1);
        tick(10);
        check("rf held off", rf_enable, 1'b0);
        send(CMD_FREQ_SET, 1'b1, 1'b1);
        tick(10);
        check("rf after freq", rf_enable, 1'b1);
        for (int e = 1; e >= 0; e--)
        begin
            send(e ? CMD_EXT_TAG_ON : CMD_EXT_TAG_OFF, 1'b1, 1'b1);
            tick(10);
            check("ext mode", extended_tag_mode, e[0]);
            clear();
            pin_event(1, 8'h00);
            tick(10);
            check("wiegand conflict", seen[K_WIEGAND], !e[0]);
        end
        // The middle byte is sent while the host stalls.
        for (int i = 0; i < 3; i++)
        begin
            clear();
            stall <= (i == 1);
            pin_event(0, 8'h5A * i[7:0]);
            tick(10);
            if (i == 1)
            begin
                check("held valid", msg_valid, 1'b1);
                check("held byte", msg.data, 8'h5A);
                stall <= 1'b0;
                tick(5);
            end
            check("bad status", seen[K_BAD_STATUS], i != 0);
            if (i != 0)
                check("status byte", last_data, 8'h5A * i[7:0]);
        end
        for (int a = 0; a < 2; a++)
        begin
            send(CMD_PARAM_UPDATE, 1'b1, 1'b1);
            rf_ack_pin <= a[0];
            tick(4);
            rf_ack_pin <= 1'b0;
            wait_kind(K_ACK_MISSING, ACK_TIMEOUT_CYC + 30);
            check("ack warning", seen[K_ACK_MISSING], !a[0]);
        end
        rf_init_done_pin <= 1'b0;
        send(CMD_FREQ_SET, 1'b1, 1'b1);
        wait_kind(K_INIT_TIMEOUT, INIT_TIMEOUT_CYC + 50);
        check("init warning", seen[K_INIT_TIMEOUT], 1'b1);
        rf_init_done_pin <= 1'b1;
        send(CMD_RF_STATUS, 1'b1, 1'b1);
        wait_kind(K_RF_STATUS, 20);
        check("no latch", last_data[0], 1'b1);
        wrap_up();
    end
endmodule
